// ==== common/decim_cfg_pkg.sv ====
// Constants shared by the decimation and idle-timing configuration block
package decim_cfg_pkg;
   // Register offsets
   localparam logic [7:0] CUBIC_UPPER_ADDR = 8'h1A;
   localparam logic [7:0] CUBIC_LOWER_ADDR = 8'h1B;
   localparam logic [7:0] GAP_CTRL_ADDR    = 8'h1C;
   localparam logic [7:0] SYNC_CTRL_ADDR   = 8'h1D;
   // Reset values
   localparam logic [7:0] CUBIC_UPPER_RST  = 8'h00;
   localparam logic [7:0] CUBIC_LOWER_RST  = 8'h00;
   localparam logic [7:0] GAP_CTRL_RST     = 8'h00;
   localparam logic [7:0] SYNC_CTRL_RST    = 8'h80;
   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] CUBIC_UPPER_MASK = 8'h1F;
   localparam logic [7:0] SYNC_CTRL_MASK   = 8'hCB;
   // Field widths
   localparam int unsigned CUBIC_W    = 13;
   localparam int unsigned CUBIC_HI_W = 5;
   localparam int unsigned RATIO_W    = 19;
   localparam int unsigned GAP_W      = 8;
   localparam int unsigned GAP_CNT_W  = 10;
   // Third-order ratio scaling: (value + 1) * 2^CUBIC_SHIFT
   localparam int unsigned CUBIC_SHIFT = 5;
   // Filter style codes
   localparam logic [2:0] STYLE_WIDE    = 3'h0;
   localparam logic [2:0] STYLE_X8      = 3'h1;
   localparam logic [2:0] STYLE_X16     = 3'h2;
   localparam logic [2:0] STYLE_CUBIC   = 3'h3;
   localparam logic [2:0] STYLE_RIPPLE  = 3'h4;
   // Fixed ratios of the two narrow-path styles
   localparam logic [RATIO_W-1:0] RATIO_X8  = 19'h00008;
   localparam logic [RATIO_W-1:0] RATIO_X16 = 19'h00010;
   // Power modes
   localparam logic [1:0] PWR_LOW    = 2'h0;
   localparam logic [1:0] PWR_MEDIAN = 2'h2;
   localparam logic [1:0] PWR_FAST   = 2'h3;
endpackage : decim_cfg_pkg

// ==== common/idle_gap_if.sv ====
// Carrier between the configuration top and the standby gap timer
`timescale 1ns/1ps
interface idle_gap_if;
   import decim_cfg_pkg::*;
   logic             start;     // Conversion ended, begin standby
   logic [GAP_W-1:0] gap_value; // Programmed idle-time field
   logic             word_stb;  // One filter output-word period elapsed
   logic             standby;   // Idle phase in progress
   logic             wake;      // Pulse: idle phase finished
   modport ctrl  (output start, output gap_value, output word_stb,
                  input standby, input wake);
   modport timer (input start, input gap_value, input word_stb,
                  output standby, output wake);
endinterface : idle_gap_if

// ==== hw/idle_gap_timer.sv ====
// Standby gap timer for periodic conversion
`timescale 1ns/1ps
module idle_gap_timer (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   // Control carrier
   idle_gap_if.timer gap
);
   import decim_cfg_pkg::*;

   logic [GAP_CNT_W-1:0] left_q; // Output periods still to wait
   logic [GAP_CNT_W-1:0] load_d; // (value + 1) * 2

   // Load figure; widened first so 0xFF does not wrap
   always_comb begin
      load_d = ({2'b00, gap.gap_value} + 10'h001) << 1;
   end

   // Down counter ticks once per filter output word
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         left_q <= '0;
      end else if (gap.start) begin
         left_q <= load_d;
      end else if (gap.word_stb && left_q != '0) begin
         left_q <= left_q - 10'h001;
      end
   end

   // Standby flag and wake pulse
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gap.standby <= 1'b0;
         gap.wake    <= 1'b0;
      end else begin
         gap.standby <= gap.start || (left_q > 10'h001) || (left_q == 10'h001 && !gap.word_stb);
         gap.wake    <= !gap.start && gap.word_stb && left_q == 10'h001;
      end
   end
endmodule : idle_gap_timer

// ==== hw/decim_idle_cfg.sv ====
// Decimation ratio selection and periodic idle timing configuration
//
// Behaviour
// - Code used only for wideband or ripple styles
// - Style 011 takes the 13-bit ratio value
// - Third-order ratio is (value plus one) times 32
// - Upper register holds value bits 12..8
// - Lower register holds value bits 7..0
// - Periodic mode idles between conversions, except in fast power mode
// - Idle unit is one filter output period
// - Idle length is (value plus one) times two
// - Reset loads 0x00, 0x00, 0x00 and 0x80
`timescale 1ns/1ps
module decim_idle_cfg (
   // Clock and reset
   input  wire logic                              core_clk_i,
   input  wire logic                              resetn_i,
   // Register port from the serial control decoder
   input  wire logic [7:0]                        reg_addr_i,
   input  wire logic [7:0]                        reg_wdata_i,
   input  wire logic                              reg_wr_i,
   input  wire logic                              reg_rd_i,
   output logic      [7:0]                        reg_rdata_o,
   output logic                                   reg_rvalid_o,
   output logic                                   reg_hit_o,
   // Filter configuration from neighbouring registers
   input  wire logic [2:0]                        filter_style_i,
   input  wire logic [2:0]                        decimation_code_i,
   input  wire logic [1:0]                        power_mode_i,
   input  wire logic                              periodic_en_i,
   // Conversion timing
   input  wire logic                              out_word_stb_i,
   input  wire logic                              conv_done_i,
   // Results
   output logic      [decim_cfg_pkg::RATIO_W-1:0] decim_ratio_o,
   output logic                                   ratio_valid_o,
   output logic      [7:0]                        sync_ctrl_o,
   output logic                                   standby_o,
   output logic                                   wake_o
);
   import decim_cfg_pkg::*;

   logic [7:0]         cubic_upper_q; // Upper ratio register
   logic [7:0]         cubic_lower_q; // Lower ratio register
   logic [7:0]         gap_ctrl_q;    // Idle-time register
   logic [7:0]         sync_ctrl_q;   // Sync and soft reset register
   logic [CUBIC_W-1:0] third_order_ratio_value; // Joined 13-bit value
   logic [RATIO_W-1:0] ratio_d;       // Selected ratio
   logic               valid_d;       // Style is a usable one
   logic [7:0]         rdata_d;       // Read mux
   logic               hit_d;         // Address decodes to this block
   logic               periodic_ok;   // Periodic mode allowed now

   idle_gap_if gap ();

   // Register writes; reserved bits never store
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cubic_upper_q <= CUBIC_UPPER_RST;
         cubic_lower_q <= CUBIC_LOWER_RST;
         gap_ctrl_q    <= GAP_CTRL_RST;
         sync_ctrl_q   <= SYNC_CTRL_RST;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            CUBIC_UPPER_ADDR: begin
               cubic_upper_q <= reg_wdata_i & CUBIC_UPPER_MASK;
            end
            CUBIC_LOWER_ADDR: begin
               cubic_lower_q <= reg_wdata_i;
            end
            GAP_CTRL_ADDR: begin
               gap_ctrl_q <= reg_wdata_i;
            end
            SYNC_CTRL_ADDR: begin
               // Only stored here; its actions live elsewhere
               sync_ctrl_q <= reg_wdata_i & SYNC_CTRL_MASK;
            end
            default: begin
               // Other offsets belong to other blocks
            end
         endcase
      end
   end

   // Join the split value; upper field sits in bits 4..0
   assign third_order_ratio_value = {cubic_upper_q[CUBIC_HI_W-1:0], cubic_lower_q};

   // Read mux and decode
   always_comb begin
      rdata_d = 8'h00;
      hit_d   = 1'b1;
      unique case (reg_addr_i)
         CUBIC_UPPER_ADDR: rdata_d = cubic_upper_q;
         CUBIC_LOWER_ADDR: rdata_d = cubic_lower_q;
         GAP_CTRL_ADDR:    rdata_d = gap_ctrl_q;
         SYNC_CTRL_ADDR:   rdata_d = sync_ctrl_q;
         default:          hit_d   = 1'b0;
      endcase
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
         reg_hit_o    <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         reg_hit_o    <= reg_rd_i && hit_d;
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
         end
      end
   end

   // Ratio selection per filter style
   always_comb begin
      ratio_d = '0;
      valid_d = 1'b1;
      unique case (filter_style_i)
         STYLE_WIDE, STYLE_RIPPLE: begin
            // Codes above 101 saturate at x1024
            if (decimation_code_i > 3'h5) begin
               ratio_d = RATIO_W'(32'd1024);
            end else begin
               ratio_d = RATIO_W'(32'd32 << decimation_code_i);
            end
         end
         STYLE_X8:  ratio_d = RATIO_X8;
         STYLE_X16: ratio_d = RATIO_X16;
         STYLE_CUBIC: begin
            // 19 bits hold 8192 * 32 without overflow
            ratio_d = ({6'h00, third_order_ratio_value} + 19'h00001) << CUBIC_SHIFT;
         end
         default: valid_d = 1'b0; // Unused style codes
      endcase
   end

   // Ratio outputs registered so they change cleanly
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         decim_ratio_o <= '0;
         ratio_valid_o <= 1'b0;
      end else begin
         decim_ratio_o <= ratio_d;
         ratio_valid_o <= valid_d;
      end
   end

   // Copy of the sync register for the neighbouring logic
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_ctrl_o <= SYNC_CTRL_RST;
      end else begin
         sync_ctrl_o <= sync_ctrl_q;
      end
   end

   // Fast mode has no standby gap; refused here as a safety net
   assign periodic_ok = periodic_en_i && (power_mode_i != PWR_FAST);

   // Drive the gap timer
   assign gap.start     = periodic_ok && conv_done_i;
   assign gap.gap_value = gap_ctrl_q;
   assign gap.word_stb  = out_word_stb_i;

   idle_gap_timer u_gap (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .gap        (gap.timer)
   );

   // Both come from flops inside the timer
   assign standby_o = gap.standby;
   assign wake_o    = gap.wake;
endmodule : decim_idle_cfg

// ==== test/decim_idle_cfg_sva.sv ====
// Assertion checker for the decimation and idle timing block
`timescale 1ns/1ps
module decim_idle_cfg_sva
   import decim_cfg_pkg::*;
(
   // Clock, reset and single-bit ports
   input wire logic core_clk_i, resetn_i, reg_rd_i, reg_rvalid_o, reg_hit_o,
   input wire logic periodic_en_i, conv_done_i, standby_o, wake_o, ratio_valid_o,
   // Buses
   input wire logic [7:0] reg_addr_i, reg_rdata_o,
   input wire logic [2:0] filter_style_i, decimation_code_i,
   input wire logic [1:0] power_mode_i,
   input wire logic [RATIO_W-1:0] decim_ratio_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // Styles that use the three-bit code
   wire cs = filter_style_i == STYLE_WIDE || filter_style_i == STYLE_RIPPLE;
   // Read inside the mapped window
   sequence s_map; reg_rd_i && reg_addr_i inside {[8'h1A:8'h1D]}; endsequence
   // Conversion end that may start an idle gap
   sequence s_go; conv_done_i && periodic_en_i && power_mode_i != PWR_FAST; endsequence
   property p_hit; s_map |=> reg_rvalid_o && reg_hit_o; endproperty
   a_hit: assert property (p_hit) else $error("mapped read not hit");
   // Unmapped offset spelled out; a sequence method is avoided inside a boolean term
   property p_miss; reg_rd_i && !(reg_addr_i inside {[CUBIC_UPPER_ADDR:SYNC_CTRL_ADDR]})
      |=> !reg_hit_o && reg_rdata_o == 8'h00; endproperty
   a_miss: assert property (p_miss) else $error("unmapped read answered");
   property p_rsv; reg_rd_i && reg_addr_i == CUBIC_UPPER_ADDR |=> reg_rdata_o[7:5] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved upper bits set");
   property p_code; cs && decimation_code_i <= 3'h5
      |=> decim_ratio_o == (19'h00020 << $past(decimation_code_i)); endproperty
   a_code: assert property (p_code) else $error("code ratio wrong");
   property p_top; cs && decimation_code_i > 3'h5 |=> decim_ratio_o == 19'h00400; endproperty
   a_top: assert property (p_top) else $error("top code ratio wrong");
   property p_inv; filter_style_i > STYLE_RIPPLE |=> !ratio_valid_o; endproperty
   a_inv: assert property (p_inv) else $error("unused style valid");
   property p_go; s_go |=> standby_o; endproperty
   a_go: assert property (p_go) else $error("standby not entered");
   property p_fast; conv_done_i && power_mode_i == PWR_FAST && !standby_o |=> !standby_o; endproperty
   a_fast: assert property (p_fast) else $error("standby in fast mode");
   property p_wake; wake_o |-> $fell(standby_o); endproperty
   a_wake: assert property (p_wake) else $error("wake without gap end");
endmodule : decim_idle_cfg_sva
bind decim_idle_cfg decim_idle_cfg_sva u_sva (.*);

// ==== test/tb_top.sv ====
// Self-checking bench for the decimation and idle timing block
`timescale 1ns/1ps
module tb_top;
   import decim_cfg_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, pe = 0, stb = 0, cd = 0;
   logic [7:0] ad = 0, wd = 0;
   logic [2:0] fs = 0, dc = 0;
   logic [1:0] pm = 0;
   wire logic [7:0] rdat, sync;
   wire logic rv, hit, rval, sb, wk;
   wire logic [RATIO_W-1:0] ratio;
   int err_count = 0, total_checks = 0, cyc = 0, n, g;
   logic [7:0] mem [8'h1A:8'h1D]; // Register model
   decim_idle_cfg DUT (.core_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(ad), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .reg_hit_o(hit),
      .filter_style_i(fs), .decimation_code_i(dc), .power_mode_i(pm), .periodic_en_i(pe),
      .out_word_stb_i(stb), .conv_done_i(cd), .decim_ratio_o(ratio), .ratio_valid_o(rval),
      .sync_ctrl_o(sync), .standby_o(sb), .wake_o(wk));
   initial forever #4 clk = ~clk;
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Register answers: {rvalid, hit, data}
   task automatic chk_reg(input logic [9:0] got, input logic [9:0] exp);
      cmp(got, exp);
   endtask : chk_reg
   // Ratio results: {valid, ratio}
   task automatic chk_rat(input logic [19:0] got, input logic [19:0] exp);
      cmp(got, exp);
   endtask : chk_rat
   // Idle gap counts and standby level
   task automatic chk_gap(input logic [9:0] got, input logic [9:0] exp);
      cmp(got, exp);
   endtask : chk_gap
   // One write strobe; model keeps only writable bits
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {ad, wd, wr} = {a, d, 1'b1};
      @(posedge clk);
      #1 wr = 0;
      if (a inside {[8'h1A:8'h1D]})
         mem[a] = d & (a == 8'h1A ? CUBIC_UPPER_MASK : a == 8'h1D ? SYNC_CTRL_MASK : 8'hFF);
   endtask : wrt
   // One read strobe; answer looked at in its single valid cycle
   task automatic rdc(input logic [7:0] a);
      @(posedge clk);
      #1 {ad, rd} = {a, 1'b1};
      @(posedge clk);
      #1 rd = 0;
      chk_reg({rv, hit, rdat}, a inside {[8'h1A:8'h1D]} ? {2'b11, mem[a]} : 10'h200);
   endtask : rdc
   // Ratio and valid flag worked out from the style table
   function automatic logic [19:0] mrat(input int s, input int c, input int v);
      if (s == 0 || s == 4) return {1'b1, 19'(c > 5 ? 1024 : 32 << c)};
      if (s == 1 || s == 2) return {1'b1, 19'(8 * s)};
      if (s == 3) return {1'b1, 19'((v + 1) * 32)};
      return 20'h0;
   endfunction : mrat
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin
      void'($urandom(11));
      mem = '{8'h00, 8'h00, 8'h00, 8'h80};
      repeat (16) @(posedge clk);
      #1 rst_n = 1;
      for (int a = 8'h1A; a <= 8'h1D; a++) rdc(8'(a));
      chk_reg({2'b00, sync}, 10'h080);
      $display("test reset done");
      // Random data over the window plus both neighbours
      repeat (8) for (int a = 8'h19; a <= 8'h1E; a++) begin
         wrt(8'(a), 8'($urandom));
         rdc(8'(a));
         chk_reg({2'b00, sync}, {2'b00, mem[8'h1D]});
      end
      $display("test registers done");
      // Mid-run reset brings every register back to its reset value
      @(posedge clk);
      #1 rst_n = 0;
      mem = '{8'h00, 8'h00, 8'h00, 8'h80};
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      for (int a = 8'h1A; a <= 8'h1D; a++) rdc(8'(a));
      chk_reg({2'b00, sync}, 10'h080);
      $display("test mid reset done");
      // Every style against every code, third-order value reloaded on each style-011 pass
      for (int k = 0; k < 64; k++) begin
         @(posedge clk);
         #1 {fs, dc} = 6'(k);
         if (fs == STYLE_CUBIC) begin
            wrt(CUBIC_UPPER_ADDR, dc == 0 ? 8'hFF : 8'($urandom));
            wrt(CUBIC_LOWER_ADDR, dc == 0 ? 8'hFF : 8'($urandom));
         end
         repeat (2) @(posedge clk);
         #1 chk_rat({rval, ratio}, mrat(fs, dc, {mem[8'h1A][4:0], mem[8'h1B]}));
      end
      $display("test ratio done");
      // Idle gaps counted in word strobes, non-fast modes only
      for (int i = 0; i < 4; i++) begin
         g = (i == 3) ? $urandom_range(255) : i;
         wrt(GAP_CTRL_ADDR, 8'(g));
         @(posedge clk);
         #1 {pe, pm, cd} = {1'b1, 2'(i % 3), 1'b1};
         @(posedge clk);
         #1 cd = 0;
         chk_gap({9'h0, sb}, 10'h001);
         n = 0;
         while (n < 600) begin
            @(posedge clk);
            #1 stb = 1;
            n++;
            @(posedge clk);
            #1 stb = 0;
            if (wk === 1'b1) break;
         end
         chk_gap(10'(n), 10'((g + 1) * 2));
      end
      // Conversion end in fast mode, then with periodic mode off, leaves the block awake
      @(posedge clk);
      #1 {pm, cd} = {PWR_FAST, 1'b1};
      @(posedge clk);
      #1 {pe, pm} = {1'b0, PWR_MEDIAN};
      @(posedge clk);
      #1 cd = 0;
      chk_gap({9'h0, sb}, 10'h000);
      @(posedge clk);
      #1 chk_gap({9'h0, sb}, 10'h000);
      $display("test idle gap done");
      test_done();
   end
endmodule : tb_top
